// ===== bench/dbm_assertions.sv
`timescale 1ns/10ps
module dbm_assertions (
  input logic clk_sys,                    // system clock
  input logic rst,                        // async reset, high
  input logic bus_request_out,            // dma asks for the bus
  input logic bus_grant_in,               // host has let go
  input logic address_enable_out,         // dma cycle span
  input logic upper_address_latch_strobe, // upper byte capture
  input logic memory_read_strobe,         // memory read
  input logic memory_write_strobe,        // memory write
  input logic block_end_flag,             // last cycle
  input logic block_marker,               // modulo mark
  input logic ready,                      // slow target ready
  input logic io_read_dev_oe,             // dma drives io read
  input logic io_write_dev_oe,            // dma drives io write
  input logic data_dev_oe                 // dma drives data lines
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  aen_span_a: assert property (address_enable_out |-> bus_grant_in && bus_request_out)
    else $error("address enable outside a granted request");
  aen_after_req_a: assert property ($rose(address_enable_out) |-> $past(bus_request_out, 2) && bus_grant_in)
    else $error("address enable rose without earlier request");
  ustb_pulse_a: assert property (upper_address_latch_strobe |-> address_enable_out && data_dev_oe ##1 !upper_address_latch_strobe)
    else $error("upper latch strobe not a one cycle pulse with data driven");
  self_desel_a: assert property (address_enable_out && data_dev_oe |-> upper_address_latch_strobe)
    else $error("data lines driven in dma outside the address phase");
  mem_in_dma_a: assert property (memory_read_strobe || memory_write_strobe |-> address_enable_out)
    else $error("memory strobe outside a dma cycle");
  memory_write_strobe_timing_a: assert property ($rose(memory_write_strobe) |-> $past(upper_address_latch_strobe, 2))
    else $error("memory write rose at the wrong cycle");
  tc_after_ready_a: assert property (block_end_flag |-> $past(ready))
    else $error("cycle ended while ready was low");
  io_own_a: assert property (io_read_dev_oe || io_write_dev_oe |-> bus_grant_in)
    else $error("io strobe driven without the bus");
  tc_release_a: assert property (block_end_flag |=> !bus_request_out && !address_enable_out && !memory_read_strobe)
    else $error("bus not released after block end");
  mark_pulse_a: assert property (block_marker |-> address_enable_out ##1 !block_marker)
    else $error("marker not a one cycle pulse in dma");
endmodule

// ===== bench/dma_bus_master_strobes_tb.sv
`timescale 1ns/10ps
module dma_bus_master_strobes_tb;
  import dbm_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       xfer_start = 1'b0;
  dbm_xfer_e  xfer_type = XF_FROM_MEM;
  logic [15:0] xfer_addr = 16'h1234;
  logic [13:0] xfer_count = 14'h0001;
  logic [7:0] reg_rd_data = 8'h00;
  logic       cpu_wr_req = 1'b0;
  logic       cpu_rd_req = 1'b0;
  logic [3:0] cpu_addr = 4'h0;
  logic [7:0] cpu_wdata = 8'h00;
  logic       sys_ready = 1'b1;
  logic       cpu_ack, cpu_busy, periph_deselect, xfer_done, xfer_busy, reg_wr_valid, f_wr_valid;
  logic [8:0] lo_addr;
  logic [7:0] cpu_rdata, reg_wr_data, f_wr_data, hi_byte, wr_data, fwr_data;
  logic [3:0] reg_wr_addr, wr_addr;
  int         fail_count, checks, cyc, n_memory_read_strobe, n_memory_write_strobe, n_ior, n_iow, n_ustb, n_tc, n_desel, n_wr, n_fwr;
  int         mark_at[$];

  always #25 clk_sys = ~clk_sys;

  dbm_if bus_if ();
  dbm_if flt_if ();
  dbm_host dbm_host_inst (.bus(bus_if), .clk_sys(clk_sys), .rst(rst), .cpu_wr_req(cpu_wr_req),
    .cpu_rd_req(cpu_rd_req), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .sys_ready(sys_ready),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .cpu_busy(cpu_busy), .periph_deselect(periph_deselect));
  dbm_device dbm_device_inst (.bus(bus_if), .clk_sys(clk_sys), .rst(rst), .xfer_start(xfer_start),
    .xfer_type(xfer_type), .xfer_addr(xfer_addr), .xfer_count(xfer_count), .reg_rd_data(reg_rd_data),
    .xfer_busy(xfer_busy), .xfer_done(xfer_done), .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data));
  // second device faces a bench driver that misuses select during a write
  dbm_device dbm_device_flt_inst (.bus(flt_if), .clk_sys(clk_sys), .rst(rst), .xfer_start(1'b0),
    .xfer_type(xfer_type), .xfer_addr(xfer_addr), .xfer_count(xfer_count), .reg_rd_data(reg_rd_data),
    .xfer_busy(), .xfer_done(), .reg_wr_valid(f_wr_valid), .reg_wr_addr(), .reg_wr_data(f_wr_data));
  dbm_assertions dbm_assertions_inst (.clk_sys(clk_sys), .rst(rst), .bus_request_out(bus_if.bus_request_out),
    .bus_grant_in(bus_if.bus_grant_in), .address_enable_out(bus_if.address_enable_out),
    .upper_address_latch_strobe(bus_if.upper_address_latch_strobe),
    .memory_read_strobe(bus_if.memory_read_strobe), .memory_write_strobe(bus_if.memory_write_strobe),
    .block_end_flag(bus_if.block_end_flag), .block_marker(bus_if.block_marker), .ready(bus_if.ready),
    .io_read_dev_oe(bus_if.io_read_dev_oe), .io_write_dev_oe(bus_if.io_write_dev_oe),
    .data_dev_oe(bus_if.data_dev_oe));

  // sampled mid-cycle so flop updates have settled
  always @(negedge clk_sys) begin
    if (bus_if.address_enable_out === 1'b1) begin
      n_memory_read_strobe += (bus_if.memory_read_strobe === 1'b1);
      n_memory_write_strobe += (bus_if.memory_write_strobe === 1'b1);
      n_ior += (bus_if.io_read_strobe === 1'b1);
      n_iow += (bus_if.io_write_strobe === 1'b1);
    end
    if (bus_if.upper_address_latch_strobe === 1'b1) begin
      if (n_ustb == 0) begin
        hi_byte = bus_if.shared_data_lines;
        lo_addr = {bus_if.dma_addr_oe, bus_if.dma_addr_lo};
      end
      n_ustb++;
    end
    n_tc += (bus_if.block_end_flag === 1'b1);
    n_desel += (periph_deselect === 1'b1);
    if (bus_if.block_marker === 1'b1) mark_at.push_back(n_ustb);
    if (reg_wr_valid === 1'b1) begin
      n_wr++;
      wr_addr = reg_wr_addr;
      wr_data = reg_wr_data;
    end
    if (f_wr_valid === 1'b1) begin
      n_fwr++;
      fwr_data = f_wr_data;
    end
  end

  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] run length expected below 20000 seen 20000");
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic clear();
    {n_memory_read_strobe, n_memory_write_strobe, n_ior, n_iow, n_ustb, n_tc, n_desel} = '0;
    mark_at.delete();
  endtask

  task automatic run_block(input dbm_xfer_e t, input int n);
    @(posedge clk_sys);
    xfer_type <= t;
    xfer_count <= n[13:0];
    xfer_start <= 1'b1;
    @(posedge clk_sys);
    xfer_start <= 1'b0;
    @(posedge clk_sys);
    chk("block busy", 1'b1, xfer_busy);
    do @(posedge clk_sys); while (xfer_done !== 1'b1);
  endtask

  task automatic host_req(input logic wr, input logic [3:0] a, input logic [7:0] d);
    do @(posedge clk_sys); while (cpu_busy !== 1'b0);
    cpu_wr_req <= wr;
    cpu_rd_req <= !wr;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk_sys);
    cpu_wr_req <= 1'b0;
    cpu_rd_req <= 1'b0;
    do @(posedge clk_sys); while (cpu_ack !== 1'b1);
  endtask

  task automatic t_regs();
    host_req(1'b1, 4'h3, 8'hA5);
    host_req(1'b1, 4'hC, 8'h5A);
    reg_rd_data <= 8'h3C;
    host_req(1'b0, 4'h5, 8'h00);
    #1;
    chk("read byte", 8'h3C, cpu_rdata);
    repeat (4) @(posedge clk_sys);
    chk("write count", 2, n_wr);
    chk("write addr", 4'hC, wr_addr);
    chk("write data", 8'h5A, wr_data);
  endtask

  task automatic t_dirs();
    dbm_xfer_e t;
    for (int i = 0; i < 4; i++) begin
      t = dbm_xfer_e'(i);
      clear();
      run_block(t, 3);
      chk("latch pulses", 3, n_ustb);
      chk("block end", 1, n_tc);
      chk("upper byte", 8'h12, hi_byte);
      chk("low address", 9'h134, lo_addr);
      chk("mem read", t == XF_FROM_MEM || t == XF_MEM2MEM, n_memory_read_strobe > 0);
      chk("mem write", t == XF_TO_MEM || t == XF_MEM2MEM, n_memory_write_strobe > 0);
      chk("deselect", 1, n_desel > 0);
      if (t == XF_TO_MEM || t == XF_FROM_MEM) begin
        chk("io read", t == XF_TO_MEM, n_ior > 0);
        chk("io write", t == XF_FROM_MEM, n_iow > 0);
      end
    end
  endtask

  task automatic t_stall();
    int base;
    clear();
    run_block(XF_FROM_MEM, 1);
    base = n_memory_read_strobe;
    clear();
    // a zero count runs a single cycle
    run_block(XF_FROM_MEM, 0);
    chk("zero count cycles", 1, n_ustb);
    clear();
    sys_ready <= 1'b0;
    fork
      run_block(XF_FROM_MEM, 1);
      begin
        do @(posedge clk_sys); while (bus_if.memory_read_strobe !== 1'b1);
        repeat (5) @(posedge clk_sys);
        sys_ready <= 1'b1;
      end
    join
    chk("read stretch", 1, n_memory_read_strobe >= base + 4 && n_memory_read_strobe <= base + 6);
  endtask

  task automatic t_mark();
    int n;
    for (int k = 0; k < 2; k++) begin
      n = k ? 300 : 128;
      clear();
      run_block(XF_FROM_MEM, n);
      chk("marker count", n / 128, mark_at.size());
      foreach (mark_at[j]) chk("marker cycle", n % 128 + 1 + 128 * j, mark_at[j]);
    end
  endtask

  task automatic t_glitch();
    @(posedge clk_sys);
    flt_if.dev_select_n <= 1'b0;
    flt_if.reg_addr <= 4'h7;
    flt_if.data_host_o <= 8'h96;
    flt_if.data_host_oe <= 1'b1;
    flt_if.io_write_host_o <= 1'b1;
    repeat (2) begin
      @(posedge clk_sys);
      flt_if.dev_select_n <= 1'b1;
      @(posedge clk_sys);
      flt_if.dev_select_n <= 1'b0;
    end
    @(posedge clk_sys);
    flt_if.io_write_host_o <= 1'b0;
    repeat (6) @(posedge clk_sys);
    flt_if.dev_select_n <= 1'b1;
    flt_if.data_host_oe <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("toggled select writes", 1, n_fwr);
    chk("toggled select data", 8'h96, fwr_data);
  endtask

  initial begin
    flt_if.bus_grant_in = 1'b0;
    flt_if.ready = 1'b1;
    flt_if.dev_select_n = 1'b1;
    flt_if.reg_addr = 4'h0;
    flt_if.io_read_host_o = 1'b0;
    flt_if.io_read_host_oe = 1'b1;
    flt_if.io_write_host_o = 1'b0;
    flt_if.io_write_host_oe = 1'b1;
    flt_if.data_host_o = 8'h00;
    flt_if.data_host_oe = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_dirs();
    t_stall();
    t_mark();
    t_glitch();
    wrap_up();
  end
endmodule

// ===== core/dbm_device.sv
`timescale 1ns/10ps
// How it works
// - ready low stretches the memory and io strobes; the upper address latch strobe stays one cycle
// - address enable high during dma cycles
// - system deselects peripherals using grant and enable
// - ignore device select while not idle
// - pulse upper address latch strobe each cycle
// - memory read for from-memory and mem-to-mem
// - memory write for to-memory and mem-to-mem
// - idle: io read is host input
// - active: drive io read for to-memory transfers
// - idle: io write is host input
// - active: drive io write for from-memory transfers
// - host ends every byte write with strobe release
// - register write taken only at strobe end
// - marker on every 128th dma cycle
// - markers counted back from block end
// - raise bus request before any service
// - host grants only after releasing its buses
// - upper address byte on data lines
// - block end flag on final cycle
module dbm_device (
  dbm_if.dev                                   bus,          // link to host and system
  input  wire logic                            clk_sys,      // system clock
  input  wire logic                            rst,          // async reset, high
  input  wire logic                            xfer_start,   // start a block, pulse
  input  wire dbm_pkg::dbm_xfer_e              xfer_type,    // direction of the block
  input  wire logic [dbm_pkg::ADDR_W-1:0]      xfer_addr,    // first memory address
  input  wire logic [dbm_pkg::COUNT_W-1:0]     xfer_count,   // dma cycles in block
  input  wire logic [dbm_pkg::DATA_W-1:0]      reg_rd_data,  // byte for host reads
  output logic                                 xfer_busy,    // block in progress
  output logic                                 xfer_done,    // block finished pulse
  output logic                                 reg_wr_valid, // host register write pulse
  output logic [dbm_pkg::REG_ADDR_W-1:0]       reg_wr_addr,  // its register address
  output logic [dbm_pkg::DATA_W-1:0]           reg_wr_data   // its byte
);
  import dbm_pkg::*;

  dbm_state_e            st_ff, nxt_st;
  dbm_xfer_e             type_ff, nxt_type;
  logic [ADDR_W-1:0]     addr_ff, nxt_addr;
  logic [COUNT_W-1:0]    left_ff, nxt_left;
  logic                  wr_prev_ff, nxt_wr_prev;
  logic                  wsel_ff, nxt_wsel;
  logic [REG_ADDR_W-1:0] waddr_ff, nxt_waddr;
  logic [DATA_W-1:0]     wdata_ff, nxt_wdata;
  logic                  wvalid_ff, nxt_wvalid;
  logic                  req_ff, nxt_req;
  logic                  aen_ff, nxt_aen;
  logic                  ustb_ff, nxt_ustb;
  logic                  memory_read_strobe_ff, nxt_memory_read_strobe;
  logic                  memory_write_strobe_ff, nxt_memory_write_strobe;
  logic                  tc_ff, nxt_tc;
  logic                  mark_ff, nxt_mark;
  logic                  aoe_ff, nxt_aoe;
  logic                  ior_ff, nxt_ior;
  logic                  iow_ff, nxt_iow;
  logic                  iooe_ff, nxt_iooe;
  logic [DATA_W-1:0]     dout_ff, nxt_dout;
  logic                  doe_ff, nxt_doe;
  logic                  busy_ff, nxt_busy;
  logic                  done_ff, nxt_done;
  logic                  reads_mem, writes_mem;
  logic                  host_sel;

  assign reads_mem  = (type_ff == XF_FROM_MEM) || (type_ff == XF_MEM2MEM);
  assign writes_mem = (type_ff == XF_TO_MEM) || (type_ff == XF_MEM2MEM);
  // select counts only in idle, so a host access cannot hit us mid-block
  assign host_sel   = (st_ff == ST_IDLE) && !bus.dev_select_n;

  always_comb begin
    nxt_st      = st_ff;
    nxt_type    = type_ff;
    nxt_addr    = addr_ff;
    nxt_left    = left_ff;
    nxt_wr_prev = 1'b0;
    nxt_wsel    = 1'b0;
    nxt_waddr   = waddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wvalid  = 1'b0;
    nxt_req     = req_ff;
    nxt_aen     = aen_ff;
    nxt_ustb    = 1'b0;
    nxt_memory_read_strobe    = memory_read_strobe_ff;
    nxt_memory_write_strobe    = memory_write_strobe_ff;
    nxt_tc      = tc_ff;
    nxt_mark    = mark_ff;
    nxt_aoe     = aoe_ff;
    nxt_ior     = ior_ff;
    nxt_iow     = iow_ff;
    nxt_iooe    = iooe_ff;
    nxt_dout    = dout_ff;
    nxt_doe     = 1'b0;
    nxt_busy    = busy_ff;
    nxt_done    = 1'b0;

    if (st_ff == ST_IDLE) begin
      // register port: io strobes are inputs here
      nxt_wr_prev = bus.io_write_strobe;
      nxt_wsel    = wsel_ff;
      if (bus.io_write_strobe && host_sel) begin
        nxt_wsel  = 1'b1;
        nxt_waddr = bus.reg_addr;
        nxt_wdata = bus.shared_data_lines;
      end
      // the byte is taken only when the strobe is released
      if (wr_prev_ff && !bus.io_write_strobe && wsel_ff) begin
        nxt_wvalid = 1'b1;
        nxt_wsel   = 1'b0;
      end
      if (bus.io_read_strobe && host_sel) begin
        nxt_dout = reg_rd_data;
        nxt_doe  = 1'b1;
      end
    end

    unique case (st_ff)
      ST_IDLE: begin
        if (xfer_start) begin
          nxt_st   = ST_REQ;
          nxt_req  = 1'b1;
          nxt_busy = 1'b1;
          nxt_type = xfer_type;
          nxt_addr = xfer_addr;
          // a zero count runs one cycle rather than wrapping
          nxt_left = (xfer_count == '0) ? COUNT_W'(1) : xfer_count;
        end
      end
      ST_REQ: begin
        if (bus.bus_grant_in) begin
          nxt_st   = ST_S1;
          nxt_aen  = 1'b1;
          nxt_iooe = 1'b1;
          nxt_aoe  = 1'b1;
        end
      end
      ST_S1: begin
        nxt_st   = ST_S2;
        nxt_ustb = 1'b1;
        nxt_dout = addr_ff[15:8];
        nxt_doe  = 1'b1;
      end
      ST_S2: begin
        nxt_st   = ST_S3;
        nxt_memory_read_strobe = reads_mem;
        nxt_ior  = (type_ff == XF_TO_MEM);
      end
      ST_S3: begin
        nxt_memory_write_strobe = writes_mem;
        nxt_iow  = (type_ff == XF_FROM_MEM);
        if (bus.ready && (memory_write_strobe_ff || iow_ff || !(writes_mem || type_ff == XF_FROM_MEM))) begin
          nxt_st   = ST_S4;
          nxt_tc   = (left_ff == COUNT_W'(1));
          nxt_mark = (left_ff[MARK_BITS-1:0] == '0);
        end
        // strobes simply hold while ready is low
      end
      ST_S4: begin
        nxt_memory_read_strobe = 1'b0;
        nxt_memory_write_strobe = 1'b0;
        nxt_ior  = 1'b0;
        nxt_iow  = 1'b0;
        nxt_tc   = 1'b0;
        nxt_mark = 1'b0;
        nxt_left = left_ff - 1'b1;
        nxt_addr = addr_ff + 1'b1;
        if (left_ff == COUNT_W'(1)) begin
          nxt_st   = ST_IDLE;
          nxt_req  = 1'b0;
          nxt_aen  = 1'b0;
          nxt_aoe  = 1'b0;
          nxt_iooe = 1'b0;
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
        end else begin
          nxt_st = ST_S1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff      <= ST_IDLE;
      type_ff    <= XF_VERIFY;
      addr_ff    <= ADDR_RST;
      left_ff    <= COUNT_RST;
      wr_prev_ff <= 1'b0;
      wsel_ff    <= 1'b0;
      waddr_ff   <= '0;
      wdata_ff   <= DATA_RST;
      wvalid_ff  <= 1'b0;
      req_ff     <= 1'b0;
      aen_ff     <= 1'b0;
      ustb_ff    <= 1'b0;
      memory_read_strobe_ff    <= 1'b0;
      memory_write_strobe_ff    <= 1'b0;
      tc_ff      <= 1'b0;
      mark_ff    <= 1'b0;
      aoe_ff     <= 1'b0;
      ior_ff     <= 1'b0;
      iow_ff     <= 1'b0;
      iooe_ff    <= 1'b0;
      dout_ff    <= DATA_RST;
      doe_ff     <= 1'b0;
      busy_ff    <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      type_ff    <= nxt_type;
      addr_ff    <= nxt_addr;
      left_ff    <= nxt_left;
      wr_prev_ff <= nxt_wr_prev;
      wsel_ff    <= nxt_wsel;
      waddr_ff   <= nxt_waddr;
      wdata_ff   <= nxt_wdata;
      wvalid_ff  <= nxt_wvalid;
      req_ff     <= nxt_req;
      aen_ff     <= nxt_aen;
      ustb_ff    <= nxt_ustb;
      memory_read_strobe_ff    <= nxt_memory_read_strobe;
      memory_write_strobe_ff    <= nxt_memory_write_strobe;
      tc_ff      <= nxt_tc;
      mark_ff    <= nxt_mark;
      aoe_ff     <= nxt_aoe;
      ior_ff     <= nxt_ior;
      iow_ff     <= nxt_iow;
      iooe_ff    <= nxt_iooe;
      dout_ff    <= nxt_dout;
      doe_ff     <= nxt_doe;
      busy_ff    <= nxt_busy;
      done_ff    <= nxt_done;
    end
  end

  assign bus.bus_request_out            = req_ff;
  assign bus.address_enable_out         = aen_ff;
  assign bus.upper_address_latch_strobe = ustb_ff;
  assign bus.memory_read_strobe         = memory_read_strobe_ff;
  assign bus.memory_write_strobe        = memory_write_strobe_ff;
  assign bus.block_end_flag             = tc_ff;
  assign bus.block_marker               = mark_ff;
  assign bus.dma_addr_lo                = addr_ff[7:0];
  assign bus.dma_addr_oe                = aoe_ff;
  assign bus.io_read_dev_o              = ior_ff;
  assign bus.io_read_dev_oe             = iooe_ff;
  assign bus.io_write_dev_o             = iow_ff;
  assign bus.io_write_dev_oe            = iooe_ff;
  assign bus.data_dev_o                 = dout_ff;
  assign bus.data_dev_oe                = doe_ff;
  assign xfer_busy                      = busy_ff;
  assign xfer_done                      = done_ff;
  assign reg_wr_valid                   = wvalid_ff;
  assign reg_wr_addr                    = waddr_ff;
  assign reg_wr_data                    = wdata_ff;
endmodule

// ===== core/dbm_host.sv
`timescale 1ns/10ps
module dbm_host (
  dbm_if.host                       bus,          // link to the dma end
  input  wire logic                 clk_sys,      // system clock
  input  wire logic                 rst,          // async reset, high
  input  wire logic                 cpu_wr_req,   // write one register byte
  input  wire logic                 cpu_rd_req,   // read one register byte
  input  wire logic [dbm_pkg::REG_ADDR_W-1:0] cpu_addr, // register address
  input  wire logic [dbm_pkg::DATA_W-1:0]     cpu_wdata, // write byte
  input  wire logic                 sys_ready,    // slow memory/peripheral ready
  output logic                      cpu_ack,      // access finished pulse
  output logic [dbm_pkg::DATA_W-1:0]          cpu_rdata, // read byte
  output logic                      cpu_busy,     // access or hold in progress
  output logic                      periph_deselect // deselect peripherals during dma
);
  import dbm_pkg::*;

  dbm_host_e               st_ff, nxt_st;
  logic [HOST_CNT_W-1:0]   cnt_ff, nxt_cnt;
  logic                    grant_ff, nxt_grant, sel_n_ff, nxt_sel_n;
  logic                    rd_ff, nxt_rd, wr_ff, nxt_wr, doe_ff, nxt_doe;
  logic [REG_ADDR_W-1:0]   addr_ff, nxt_addr;
  logic [DATA_W-1:0]       wd_ff, nxt_wd, rdata_ff, nxt_rdata;
  logic                    ack_ff, nxt_ack, busy_ff, nxt_busy, desel_ff, nxt_desel, rdy_ff, nxt_rdy;

  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_grant = grant_ff;
    nxt_sel_n = sel_n_ff;
    nxt_rd    = rd_ff;
    nxt_wr    = wr_ff;
    nxt_doe   = doe_ff;
    nxt_addr  = addr_ff;
    nxt_wd    = wd_ff;
    nxt_rdata = rdata_ff;
    nxt_ack   = 1'b0;
    nxt_busy  = busy_ff;
    nxt_rdy   = sys_ready;
    nxt_desel = grant_ff & bus.address_enable_out;
    unique case (st_ff)
      HS_RESET: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == HOST_CNT_W'(RST_FIRST_WR_CYC - 1)) begin
          nxt_st   = HS_IDLE;
          nxt_busy = 1'b0;
        end
      end
      HS_IDLE: begin
        nxt_cnt = '0;
        if (bus.bus_request_out) begin
          nxt_st    = HS_GRANT;
          nxt_grant = 1'b1;
          nxt_busy  = 1'b1;
        end else if (cpu_wr_req) begin
          nxt_st    = HS_WR;
          nxt_sel_n = 1'b0;
          nxt_wr    = 1'b1;
          nxt_doe   = 1'b1;
          nxt_addr  = cpu_addr;
          nxt_wd    = cpu_wdata;
          nxt_busy  = 1'b1;
        end else if (cpu_rd_req) begin
          nxt_st    = HS_RD;
          nxt_sel_n = 1'b0;
          nxt_rd    = 1'b1;
          nxt_addr  = cpu_addr;
          nxt_busy  = 1'b1;
        end
      end
      HS_WR: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == HOST_CNT_W'(WR_WIDTH_CYC - 1)) begin
          nxt_st = HS_WR_END;
          nxt_wr = 1'b0;
        end
      end
      HS_WR_END: begin
        nxt_st    = HS_IDLE;
        nxt_sel_n = 1'b1;
        nxt_doe   = 1'b0;
        nxt_ack   = 1'b1;
        nxt_busy  = 1'b0;
      end
      HS_RD: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == HOST_CNT_W'(RD_WIDTH_CYC - 1)) begin
          nxt_st    = HS_IDLE;
          nxt_rd    = 1'b0;
          nxt_sel_n = 1'b1;
          nxt_rdata = bus.shared_data_lines;
          nxt_ack   = 1'b1;
          nxt_busy  = 1'b0;
        end
      end
      HS_GRANT: begin
        if (!bus.bus_request_out) begin
          nxt_st    = HS_IDLE;
          nxt_grant = 1'b0;
          nxt_busy  = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff    <= HS_RESET;
      cnt_ff   <= '0;
      grant_ff <= 1'b0;
      sel_n_ff <= 1'b1;
      rd_ff    <= 1'b0;
      wr_ff    <= 1'b0;
      doe_ff   <= 1'b0;
      addr_ff  <= '0;
      wd_ff    <= DATA_RST;
      rdata_ff <= DATA_RST;
      ack_ff   <= 1'b0;
      busy_ff  <= 1'b1;
      desel_ff <= 1'b0;
      rdy_ff   <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      grant_ff <= nxt_grant;
      sel_n_ff <= nxt_sel_n;
      rd_ff    <= nxt_rd;
      wr_ff    <= nxt_wr;
      doe_ff   <= nxt_doe;
      addr_ff  <= nxt_addr;
      wd_ff    <= nxt_wd;
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
      busy_ff  <= nxt_busy;
      desel_ff <= nxt_desel;
      rdy_ff   <= nxt_rdy;
    end
  end

  assign bus.bus_grant_in     = grant_ff;
  assign bus.dev_select_n     = sel_n_ff;
  assign bus.reg_addr         = addr_ff;
  assign bus.ready            = rdy_ff;
  assign bus.io_read_host_o   = rd_ff;
  assign bus.io_read_host_oe  = ~grant_ff;
  assign bus.io_write_host_o  = wr_ff;
  assign bus.io_write_host_oe = ~grant_ff;
  assign bus.data_host_o      = wd_ff;
  assign bus.data_host_oe     = doe_ff;
  assign cpu_ack              = ack_ff;
  assign cpu_rdata            = rdata_ff;
  assign cpu_busy             = busy_ff;
  assign periph_deselect      = desel_ff;
endmodule

// ===== core/dbm_if.sv
`timescale 1ns/10ps
interface dbm_if;
  import dbm_pkg::*;

  logic                  bus_request_out;
  logic                  bus_grant_in;
  logic                  address_enable_out;
  logic                  upper_address_latch_strobe;
  logic                  memory_read_strobe;
  logic                  memory_write_strobe;
  logic                  block_end_flag;
  logic                  block_marker;
  logic                  ready;
  logic                  dev_select_n;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [7:0]            dma_addr_lo;
  logic                  dma_addr_oe;
  logic                  io_read_dev_o;
  logic                  io_read_dev_oe;
  logic                  io_read_host_o;
  logic                  io_read_host_oe;
  logic                  io_write_dev_o;
  logic                  io_write_dev_oe;
  logic                  io_write_host_o;
  logic                  io_write_host_oe;
  logic [DATA_W-1:0]     data_dev_o;
  logic                  data_dev_oe;
  logic [DATA_W-1:0]     data_host_o;
  logic                  data_host_oe;
  logic                  io_read_strobe;
  logic                  io_write_strobe;
  logic [DATA_W-1:0]     shared_data_lines;

  // resolved wire levels; an undriven line reads as deasserted / zero
  assign io_read_strobe    = io_read_dev_oe ? io_read_dev_o : (io_read_host_oe & io_read_host_o);
  assign io_write_strobe   = io_write_dev_oe ? io_write_dev_o : (io_write_host_oe & io_write_host_o);
  assign shared_data_lines = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : '0);

  modport dev (
    output bus_request_out, address_enable_out, upper_address_latch_strobe,
    output memory_read_strobe, memory_write_strobe, block_end_flag, block_marker,
    output dma_addr_lo, dma_addr_oe, io_read_dev_o, io_read_dev_oe,
    output io_write_dev_o, io_write_dev_oe, data_dev_o, data_dev_oe,
    input  bus_grant_in, ready, dev_select_n, reg_addr,
    input  io_read_strobe, io_write_strobe, shared_data_lines
  );

  modport host (
    output bus_grant_in, ready, dev_select_n, reg_addr,
    output io_read_host_o, io_read_host_oe, io_write_host_o, io_write_host_oe,
    output data_host_o, data_host_oe,
    input  bus_request_out, address_enable_out, upper_address_latch_strobe,
    input  memory_read_strobe, memory_write_strobe, block_end_flag, block_marker,
    input  dma_addr_lo, dma_addr_oe, io_read_strobe, io_write_strobe, shared_data_lines
  );
endinterface

// ===== core/dbm_pkg.sv
package dbm_pkg;

  // transfer direction as seen from memory
  typedef enum logic [1:0] {
    XF_VERIFY,
    XF_TO_MEM,
    XF_FROM_MEM,
    XF_MEM2MEM
  } dbm_xfer_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_S1,
    ST_S2,
    ST_S3,
    ST_S4
  } dbm_state_e;

  typedef enum logic [2:0] {
    HS_RESET,
    HS_IDLE,
    HS_WR,
    HS_WR_END,
    HS_RD,
    HS_GRANT
  } dbm_host_e;

  localparam int          CLK_MHZ          = 20;
  localparam int          MARK_PERIOD      = 128;
  localparam int          MARK_BITS        = $clog2(MARK_PERIOD);
  localparam int          ADDR_W           = 16;
  localparam int          COUNT_W          = 14;
  localparam int          REG_ADDR_W       = 4;
  localparam int          DATA_W           = 8;
  localparam int          WR_WIDTH_NS      = 100;
  localparam int          RD_WIDTH_NS      = 200;
  localparam int          WR_WIDTH_CYC     = (WR_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int          RD_WIDTH_CYC     = (RD_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int          RST_FIRST_WR_CYC = 2;
  localparam int          HOST_CNT_W       = 4;
  localparam logic [15:0] ADDR_RST         = 16'h0000;
  localparam logic [13:0] COUNT_RST        = 14'h0000;
  localparam logic [7:0]  DATA_RST         = 8'h00;

endpackage
